// ---- verilog/liudp_port.sv ----
// Contract
// (RQ1) Hunt 2^15-1 (DS3/STS-1) or 2^23-1 (E3)
// (RQ2) Status high while detector unsynchronized
// (RQ3) Locked: status low, pulse per error
// (RQ4) Extended features off: status output undriven
// (RQ5) Receive clock from master clock during loss
// (RQ6) Receive outputs fall edge; rise when floating
// (RQ7) Monitor select sets preamp and receive attenuator
// (RQ8) Codec off: pulses follow line polarity
// (RQ9) Codec on: NRZ data, violation pulses
// (RQ10) Transmit sampled rising at 0, else falling
// (RQ11) Far end supplies transmit clock per rate
// (RQ12) Source bit0 used only with features on
// (RQ13) Feature enable: off, on, test mode
// (RQ14) Rate select: E3, DS3, STS-1
// (RQ15) Three-state pins resolved to stable values
module liudp_port
	import liudp_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic rx_rec_clk_i,
	input wire logic mst_clk_i,
	input wire logic tx_line_clock_i,
	input wire logic [LIUDP_NUM_CFG-1:0] cfg_pu_i,
	input wire logic [LIUDP_NUM_CFG-1:0] cfg_pd_i,
	input wire logic signal_loss_n_i,
	input wire logic zero_sub_codec_disable_n_i,
	input wire liudp_sym_t rx_line_i,
	input wire logic tx_positive_in_i,
	input wire logic tx_negative_in_i,
	output logic rx_clk_o,
	output logic rx_positive_pulse_o,
	output logic rx_negative_pulse_o,
	output logic prbs_status_o,
	output logic prbs_status_oe_n_o,
	output logic preamp_en_o,
	output logic rx_jitter_atten_en_o,
	output logic test_mode_o,
	output liudp_rate_t rate_mode_o,
	output logic [15:0] tx_clk_khz_o,
	output liudp_txsel_t tx_source_sel_o,
	output liudp_sym_t tx_data_o
);
	function automatic logic [15:0] rate_khz(input liudp_rate_t r);
		unique case (r)
			RATE_E3: rate_khz = LIUDP_KHZ_E3;
			RATE_DS3: rate_khz = LIUDP_KHZ_DS3;
			default: rate_khz = LIUDP_KHZ_STS1;
		endcase
	endfunction

	function automatic liudp_rate_t tri_rate(input liudp_tri_t t);
		unique case (t)
			TRI_LOW: tri_rate = RATE_E3;
			TRI_HIGH: tri_rate = RATE_DS3;
			default: tri_rate = RATE_STS1;
		endcase
	endfunction

	// ---------------- Configuration pins, reference clock ----------------
	liudp_tri_t cfg_lvl [LIUDP_NUM_CFG];

	for (genvar g = 0; g < LIUDP_NUM_CFG; g++) begin : g_pin
		liudp_tri_resolve #(
			.SETTLE(LIUDP_SETTLE_CYCLES),
			.INIT(LIUDP_TRI_RST)
		) u_res (
			.ref_clk_i(ref_clk_i),
			.reset_i(reset_i),
			.pu_i(cfg_pu_i[g]),
			.pd_i(cfg_pd_i[g]),
			.level_o(cfg_lvl[g])
		);
	end

	liudp_tri_t edge_lvl;
	liudp_tri_t mon_lvl;
	liudp_tri_t feat_lvl;
	liudp_tri_t rate_lvl;

	assign edge_lvl = cfg_lvl[LIUDP_PIN_EDGE];
	assign mon_lvl = cfg_lvl[LIUDP_PIN_MON];
	assign feat_lvl = cfg_lvl[LIUDP_PIN_FEAT];
	assign rate_lvl = cfg_lvl[LIUDP_PIN_RATE];

	logic loss_s1_q;
	logic loss_s2_q;

	always_ff @(posedge ref_clk_i) begin
		loss_s1_q <= signal_loss_n_i;
		loss_s2_q <= loss_s1_q;
	end

	logic preamp_q, preamp_d;
	logic rxja_q, rxja_d;
	logic test_q, test_d;
	logic oe_n_q, oe_n_d;
	logic clk_sel_q, clk_sel_d;
	liudp_rate_t rate_q, rate_d;
	logic [15:0] khz_q, khz_d;
	liudp_txsel_t txsel_q, txsel_d;

	always_comb begin
		preamp_d = mon_lvl == TRI_HIGH; // [RQ7]
		rxja_d = mon_lvl == TRI_FLOAT; // [RQ7]
		test_d = feat_lvl == TRI_FLOAT; // [RQ13]
		oe_n_d = feat_lvl != TRI_HIGH; // [RQ4] [RQ13]
		clk_sel_d = !loss_s2_q; // [RQ5]
		rate_d = tri_rate(rate_lvl); // [RQ14]
		khz_d = rate_khz(rate_d); // [RQ14]
		txsel_d.rate = rate_d;
		txsel_d.bit1 = cfg_lvl[LIUDP_PIN_SRC1] == TRI_HIGH;
		// Bit0 only counts with extended features on
		txsel_d.bit0 = feat_lvl == TRI_HIGH && cfg_lvl[LIUDP_PIN_SRC0] == TRI_HIGH; // [RQ12]
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			preamp_q <= 1'b0;
			rxja_q <= 1'b0;
			test_q <= 1'b0;
			oe_n_q <= 1'b1;
			clk_sel_q <= 1'b0;
			rate_q <= RATE_E3;
			khz_q <= LIUDP_KHZ_E3;
			txsel_q <= '{bit1: 1'b0, bit0: 1'b0, rate: RATE_E3};
		end else begin
			preamp_q <= preamp_d;
			rxja_q <= rxja_d;
			test_q <= test_d;
			oe_n_q <= oe_n_d;
			clk_sel_q <= clk_sel_d;
			rate_q <= rate_d;
			khz_q <= khz_d;
			txsel_q <= txsel_d;
		end
	end

	assign preamp_en_o = preamp_q;
	assign rx_jitter_atten_en_o = rxja_q;
	assign test_mode_o = test_q;
	assign prbs_status_oe_n_o = oe_n_q;
	assign rate_mode_o = rate_q;
	assign tx_clk_khz_o = khz_q; // [RQ11]
	assign tx_source_sel_o = txsel_q;

	// Plain mux: a switch may clip one receive clock cycle
	assign rx_clk_o = clk_sel_q ? mst_clk_i : rx_rec_clk_i; // [RQ5]

	// ---------------- Receive side, recovered clock ----------------
	// Resolved levels are stable for the settle time, so bits cross together
	logic [5:0] rx_s1_q;
	logic [5:0] rx_s2_q;

	always_ff @(posedge rx_rec_clk_i) begin
		rx_s1_q <= {reset_i, zero_sub_codec_disable_n_i, edge_lvl, rate_q};
		rx_s2_q <= rx_s1_q;
	end

	logic rx_rst;
	logic codec_off;
	liudp_tri_t rx_edge;
	liudp_rate_t rx_rate;

	assign rx_rst = rx_s2_q[5];
	assign codec_off = rx_s2_q[4];
	assign rx_edge = liudp_tri_t'(rx_s2_q[3:2]);
	assign rx_rate = liudp_rate_t'(rx_s2_q[1:0]);

	logic [2:0] hist_q, hist_d;
	logic last_neg_q, last_neg_d;
	logic pos_q, pos_d;
	logic neg_q, neg_d;
	logic pulse;
	logic kill_new;
	logic kill1;
	logic kill2;
	logic cv;
	logic dec_bit;
	logic prbs_bit;

	always_comb begin
		pulse = rx_line_i.pos || rx_line_i.neg;
		last_neg_d = last_neg_q;
		kill_new = 1'b0;
		kill1 = 1'b0;
		kill2 = 1'b0;
		cv = 1'b0;
		if (pulse) begin
			last_neg_d = rx_line_i.neg;
			// Same polarity twice in a row is a bipolar violation
			if (rx_line_i.neg == last_neg_q && !codec_off) begin
				if (rx_rate == RATE_E3) begin
					if (hist_q[1:0] == 2'b00) begin
						kill_new = 1'b1;
						kill2 = hist_q[2];
					end else begin
						cv = 1'b1; // [RQ9]
					end
				end else if (hist_q[1:0] == 2'b10) begin
					kill_new = 1'b1;
					kill1 = 1'b1;
				end else begin
					cv = 1'b1; // [RQ9]
				end
			end
		end
		// Three bits of delay cover the longest substitution
		hist_d = {hist_q[1] && !kill1, hist_q[0], pulse && !kill_new};
		dec_bit = hist_q[2] && !kill2;
		if (codec_off) begin
			pos_d = rx_line_i.pos; // [RQ8]
			neg_d = rx_line_i.neg; // [RQ8]
			prbs_bit = pulse;
		end else begin
			pos_d = dec_bit; // [RQ9]
			neg_d = cv; // [RQ9]
			prbs_bit = dec_bit;
		end
	end

	always_ff @(posedge rx_rec_clk_i) begin
		if (rx_rst) begin
			hist_q <= '0;
			last_neg_q <= 1'b1;
			pos_q <= 1'b0;
			neg_q <= 1'b0;
		end else begin
			hist_q <= hist_d;
			last_neg_q <= last_neg_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
		end
	end

	logic prbs_locked;
	logic prbs_st;

	liudp_prbs_det u_prbs (
		.clk_i(rx_rec_clk_i),
		.rst_i(rx_rst),
		.short_seq_i(rx_rate != RATE_E3), // [RQ1]
		.data_i(prbs_bit),
		.locked_o(prbs_locked),
		.status_o(prbs_st)
	);

	// Half-cycle retime gives the falling-edge update
	logic [2:0] fall_q;
	logic rise_sel;

	always_ff @(negedge rx_rec_clk_i) begin
		if (rx_rst) begin
			fall_q <= 3'h1;
		end else begin
			fall_q <= {pos_q, neg_q, prbs_st};
		end
	end

	assign rise_sel = rx_edge == TRI_FLOAT; // [RQ6]
	assign rx_positive_pulse_o = rise_sel ? pos_q : fall_q[2]; // [RQ6]
	assign rx_negative_pulse_o = rise_sel ? neg_q : fall_q[1]; // [RQ6]
	assign prbs_status_o = rise_sel ? prbs_st : fall_q[0]; // [RQ3]

	// ---------------- Transmit side, transmit clock ----------------
	logic [2:0] tx_s1_q;
	logic [2:0] tx_s2_q;

	always_ff @(posedge tx_line_clock_i) begin
		tx_s1_q <= {reset_i, edge_lvl};
		tx_s2_q <= tx_s1_q;
	end

	logic tx_rst;
	liudp_tri_t tx_edge;

	assign tx_rst = tx_s2_q[2];
	assign tx_edge = liudp_tri_t'(tx_s2_q[1:0]);

	liudp_sym_t tx_rise_q;
	liudp_sym_t tx_fall_q;
	liudp_sym_t tx_data_q, tx_data_d;

	always_ff @(posedge tx_line_clock_i) begin
		tx_rise_q <= '{pos: tx_positive_in_i, neg: tx_negative_in_i};
	end

	always_ff @(negedge tx_line_clock_i) begin
		tx_fall_q <= '{pos: tx_positive_in_i, neg: tx_negative_in_i};
	end

	always_comb begin
		tx_data_d = (tx_edge == TRI_LOW) ? tx_rise_q : tx_fall_q; // [RQ10]
	end

	always_ff @(posedge tx_line_clock_i) begin
		if (tx_rst) begin
			tx_data_q <= '0;
		end else begin
			tx_data_q <= tx_data_d;
		end
	end

	assign tx_data_o = tx_data_q;

	// ---------------- Checks ----------------
	feature_off_hiz_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ4]
		feat_lvl == TRI_LOW |=> prbs_status_oe_n_o)
		else $error("status driven with features off");

	monitor_decode_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ7]
		$stable(mon_lvl) |=> preamp_en_o == ($past(mon_lvl) == TRI_HIGH)
			&& rx_jitter_atten_en_o == ($past(mon_lvl) == TRI_FLOAT))
		else $error("monitor select decoded wrongly");

	source_bit0_mask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ12]
		feat_lvl != TRI_HIGH |=> !tx_source_sel_o.bit0)
		else $error("source bit0 used with features off");

	loss_clock_sel_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ5]
		!loss_s2_q [*2] |-> clk_sel_q)
		else $error("receive clock not from master on loss");

	rate_decode_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ14]
		rate_lvl == TRI_LOW ##1 rate_lvl == TRI_LOW |-> rate_mode_o == RATE_E3
			&& tx_clk_khz_o == LIUDP_KHZ_E3)
		else $error("rate select decoded wrongly");

	codec_off_pass_a: assert property (@(posedge rx_rec_clk_i) disable iff (rx_rst) // [RQ8]
		codec_off ##1 codec_off |-> pos_q == $past(rx_line_i.pos)
			&& neg_q == $past(rx_line_i.neg))
		else $error("line pulse not passed through");

	tx_rise_sample_a: assert property (@(posedge tx_line_clock_i) disable iff (tx_rst) // [RQ10]
		tx_edge == TRI_LOW [*3] |-> tx_data_o
			== $past({tx_positive_in_i, tx_negative_in_i}, 2))
		else $error("transmit data not taken on rising edge");

endmodule

// ---- verilog/liudp_pkg.sv ----
package liudp_pkg;

	typedef enum logic [1:0] {TRI_LOW, TRI_HIGH, TRI_FLOAT} liudp_tri_t;
	typedef enum logic [1:0] {RATE_E3, RATE_DS3, RATE_STS1} liudp_rate_t;

	typedef struct packed {
		logic pos;
		logic neg;
	} liudp_sym_t;

	typedef struct packed {
		logic bit1;
		logic bit0;
		liudp_rate_t rate;
	} liudp_txsel_t;

	// Indices into the three-state pin vectors
	localparam int LIUDP_PIN_EDGE = 0;
	localparam int LIUDP_PIN_MON = 1;
	localparam int LIUDP_PIN_FEAT = 2;
	localparam int LIUDP_PIN_RATE = 3;
	localparam int LIUDP_PIN_SRC0 = 4;
	localparam int LIUDP_PIN_SRC1 = 5;
	localparam int LIUDP_NUM_CFG = 6;

	localparam int unsigned LIUDP_REF_CLK_MHZ = 50;
	localparam int unsigned LIUDP_SETTLE_NS = 2000;
	localparam int unsigned LIUDP_SETTLE_CYCLES =
		(LIUDP_SETTLE_NS * LIUDP_REF_CLK_MHZ + 999) / 1000;
	localparam liudp_tri_t LIUDP_TRI_RST = TRI_LOW;

	localparam int unsigned LIUDP_PRBS_LOCK_BITS = 48;
	localparam int unsigned LIUDP_PRBS_LOSS_ERRS = 8;
	localparam int LIUDP_P15_LEN = 15;
	localparam int LIUDP_P15_TAP = 14;
	localparam int LIUDP_P23_LEN = 23;
	localparam int LIUDP_P23_TAP = 18;

	localparam logic [15:0] LIUDP_KHZ_DS3 = 16'haec0;
	localparam logic [15:0] LIUDP_KHZ_E3 = 16'h8640;
	localparam logic [15:0] LIUDP_KHZ_STS1 = 16'hca80;

endpackage

// ---- verilog/liudp_tri_resolve.sv ----
module liudp_tri_resolve
	import liudp_pkg::*;
#(
	parameter int unsigned SETTLE = LIUDP_SETTLE_CYCLES,
	parameter liudp_tri_t INIT = LIUDP_TRI_RST
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic pu_i,
	input wire logic pd_i,
	output liudp_tri_t level_o
);
	localparam int CW = $clog2(SETTLE + 1);

	logic [1:0] s1_q;
	logic [1:0] s2_q;
	liudp_tri_t raw;
	liudp_tri_t cand_q, cand_d;
	liudp_tri_t level_q, level_d;
	logic [CW-1:0] cnt_q, cnt_d;

	always_ff @(posedge ref_clk_i) begin
		s1_q <= {pu_i, pd_i};
		s2_q <= s1_q;
	end

	// Pulled-up and pulled-down reads agree unless the pin floats
	always_comb begin
		unique case (s2_q)
			2'b11: raw = TRI_HIGH;
			2'b00: raw = TRI_LOW;
			2'b10: raw = TRI_FLOAT;
			default: raw = cand_q;
		endcase
	end

	always_comb begin
		cand_d = cand_q;
		cnt_d = cnt_q;
		level_d = level_q;
		if (raw != cand_q) begin
			cand_d = raw;
			cnt_d = '0;
		end else if (cnt_q < CW'(SETTLE)) begin
			cnt_d = cnt_q + CW'(1);
		end
		if (raw == cand_q && cnt_q == CW'(SETTLE - 1)) begin
			level_d = cand_q; // [RQ15]
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cand_q <= INIT;
			cnt_q <= '0;
			level_q <= INIT;
		end else begin
			cand_q <= cand_d;
			cnt_q <= cnt_d;
			level_q <= level_d;
		end
	end

	assign level_o = level_q;

	settled_value_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [RQ15]
		cnt_q == CW'(SETTLE) |-> level_q == cand_q)
		else $error("settled pin level not taken");

endmodule

// ---- verilog/liudp_prbs_det.sv ----
module liudp_prbs_det
	import liudp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic short_seq_i,
	input wire logic data_i,
	output logic locked_o,
	output logic status_o
);
	localparam int GW = $clog2(LIUDP_PRBS_LOCK_BITS + 1);
	localparam int EW = $clog2(LIUDP_PRBS_LOSS_ERRS + 1);

	logic [LIUDP_P23_LEN-1:0] sr_q, sr_d;
	logic locked_q, locked_d;
	logic err_q, err_d;
	logic [GW-1:0] good_q, good_d;
	logic [EW-1:0] errs_q, errs_d;
	logic pred;
	logic miss;

	always_comb begin
		pred = short_seq_i ? sr_q[LIUDP_P15_LEN-1] ^ sr_q[LIUDP_P15_TAP-1] // [RQ1]
			: sr_q[LIUDP_P23_LEN-1] ^ sr_q[LIUDP_P23_TAP-1];
		miss = pred != data_i;
		locked_d = locked_q;
		err_d = 1'b0;
		good_d = miss ? '0 : good_q;
		errs_d = errs_q;
		// Hunting reloads from the line; locked runs free so errors show
		sr_d = {sr_q[LIUDP_P23_LEN-2:0], locked_q ? pred : data_i};
		if (!miss && good_q < GW'(LIUDP_PRBS_LOCK_BITS)) begin
			good_d = good_q + GW'(1);
		end
		if (!locked_q) begin
			errs_d = '0;
			if (good_d == GW'(LIUDP_PRBS_LOCK_BITS)) begin
				locked_d = 1'b1;
			end
		end else begin
			err_d = miss; // [RQ3]
			if (good_q == GW'(LIUDP_PRBS_LOCK_BITS)) begin
				errs_d = '0;
			end
			if (miss) begin
				errs_d = errs_q + EW'(1);
				if (errs_d == EW'(LIUDP_PRBS_LOSS_ERRS)) begin
					locked_d = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_q <= '0;
			locked_q <= 1'b0;
			err_q <= 1'b0;
			good_q <= '0;
			errs_q <= '0;
		end else begin
			sr_q <= sr_d;
			locked_q <= locked_d;
			err_q <= err_d;
			good_q <= good_d;
			errs_q <= errs_d;
		end
	end

	assign locked_o = locked_q;
	assign status_o = !locked_q || err_q; // [RQ2] [RQ3]

	sequence bit_error_s;
		locked_q && miss && locked_d;
	endsequence

	hunt_status_high_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
		!locked_q |-> status_o)
		else $error("status low while out of sync");

	error_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
		bit_error_s |=> status_o ##1 (!status_o || err_q))
		else $error("bit error not pulsed on status");

endmodule

// ---- test/liudp_framer_model.sv ----
module liudp_framer_model
	import liudp_pkg::*;
(
	input wire logic [15:0] khz_i,
	output logic tx_clk_o,
	output logic tx_pos_o,
	output logic tx_neg_o,
	output liudp_sym_t sent2_o
);
	timeunit 1ns;
	timeprecision 100ps;

	int seed = 32'h5871e808;
	liudp_sym_t h[2];

	// Rate follows the selected mode; waits for the rate output to take its reset value
	initial begin
		tx_clk_o = 1'b0;
		#50;
		forever #(500000.0 / khz_i) tx_clk_o = ~tx_clk_o;
	end

	initial begin
		tx_pos_o = 1'b0;
		tx_neg_o = 1'b0;
		sent2_o = '0;
		h[0] = '0;
		h[1] = '0;
	end

	// Data moves just after the rising edge so either sampling edge sees it settled
	always @(posedge tx_clk_o) begin
		sent2_o = h[0];
		h[1] = h[0];
		h[0] = {tx_pos_o, tx_neg_o};
		#1;
		{tx_pos_o, tx_neg_o} = 2'($random(seed));
	end
endmodule

// ---- test/liudp_port_bench.sv ----
module liudp_port_bench
	import liudp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk = 1'b0;
	logic reset, rec_clk, mst_clk, tx_clk, los_n, zdis_n, tx_positive_in, tx_negative_in;
	logic [5:0] pu, pd;
	liudp_sym_t rx_line, txd, sent2, s;
	logic rx_clk, rx_pos, rx_neg, st, st_oe_n, preamp, ja, test_m, sp, sn, ss, pol, b;
	liudp_rate_t rate;
	logic [15:0] khz;
	liudp_txsel_t txsel;
	liudp_sym_t d[4];
	logic [14:0] ps = 15'h7fff;
	int seed = 32'h5871e808;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int hits;

	initial forever #10 ref_clk = ~ref_clk;
	initial begin
		rec_clk = 1'b0;
		#7;
		forever #32 rec_clk = ~rec_clk;
	end
	initial begin
		mst_clk = 1'b0;
		forever #11 mst_clk = ~mst_clk;
	end

	liudp_port dut (.ref_clk_i(ref_clk), .reset_i(reset), .rx_rec_clk_i(rec_clk),
		.mst_clk_i(mst_clk), .tx_line_clock_i(tx_clk), .cfg_pu_i(pu), .cfg_pd_i(pd),
		.signal_loss_n_i(los_n), .zero_sub_codec_disable_n_i(zdis_n), .rx_line_i(rx_line),
		.tx_positive_in_i(tx_positive_in), .tx_negative_in_i(tx_negative_in), .rx_clk_o(rx_clk),
		.rx_positive_pulse_o(rx_pos), .rx_negative_pulse_o(rx_neg), .prbs_status_o(st),
		.prbs_status_oe_n_o(st_oe_n), .preamp_en_o(preamp), .rx_jitter_atten_en_o(ja),
		.test_mode_o(test_m), .rate_mode_o(rate), .tx_clk_khz_o(khz),
		.tx_source_sel_o(txsel), .tx_data_o(txd));

	liudp_framer_model partner (.khz_i(khz), .tx_clk_o(tx_clk), .tx_pos_o(tx_positive_in),
		.tx_neg_o(tx_negative_in), .sent2_o(sent2));

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] exp_khz(input int t);
		case (t)
			0: return 16'h8640;
			1: return 16'haec0;
			default: return 16'hca80;
		endcase
	endfunction

	// Long wait covers the glitch filter plus both synchronisers
	task automatic set_pin(input int idx, input liudp_tri_t v);
		@(posedge ref_clk);
		#1;
		pu[idx] = (v != TRI_LOW);
		pd[idx] = (v == TRI_HIGH);
		repeat (130) @(posedge ref_clk);
		#1;
	endtask

	task automatic rx_step(input liudp_sym_t v);
		@(posedge rec_clk);
		#1;
		sp = rx_pos;
		sn = rx_neg;
		ss = st;
		#1;
		rx_line = v;
		d[3] = d[2];
		d[2] = d[1];
		d[1] = d[0];
		d[0] = v;
	endtask

	task automatic ami_step(input logic one);
		if (one) begin
			pol = ~pol;
			rx_step(pol ? 2'b10 : 2'b01);
		end else begin
			rx_step(2'b00);
		end
	endtask

	task automatic prbs_run(input int n, input int flip_at);
		for (int i = 0; i < n; i++) begin
			b = ps[14] ^ ps[13];
			ps = {ps[13:0], b};
			ami_step(b ^ (i == flip_at));
			hits += ss;
		end
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end

	initial begin
		reset = 1'b1;
		pu = '0;
		pd = '0;
		los_n = 1'b1;
		zdis_n = 1'b1;
		rx_line = '0;
		pol = 1'b0;
		d = '{default: '0};
		repeat (12) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		repeat (3) @(posedge ref_clk);
		#3.5;
		check_val("oe_n", 1, st_oe_n);
		check_val("status", 1, st);
		check_val("rate", RATE_E3, rate);
		check_val("rx_clk", rec_clk, rx_clk);
		for (int t = 0; t < 3; t++) begin
			set_pin(LIUDP_PIN_RATE, liudp_tri_t'(t));
			check_val("rate", 16'(t), rate);
			check_val("khz", exp_khz(t), khz);
			set_pin(LIUDP_PIN_MON, liudp_tri_t'(t));
			check_val("preamp", t == 1, preamp);
			check_val("rx_ja", t == 2, ja);
			set_pin(LIUDP_PIN_FEAT, liudp_tri_t'(t));
			check_val("oe_n", t != 1, st_oe_n);
			check_val("test", t == 2, test_m);
		end
		set_pin(LIUDP_PIN_SRC0, TRI_HIGH);
		set_pin(LIUDP_PIN_SRC1, TRI_HIGH);
		set_pin(LIUDP_PIN_FEAT, TRI_LOW);
		check_val("sel_bit0", 0, txsel.bit0);
		set_pin(LIUDP_PIN_FEAT, TRI_HIGH);
		check_val("sel_bits", 2'b11, {txsel.bit1, txsel.bit0});
		check_val("sel_rate", RATE_STS1, txsel.rate);
		// Falling-edge update lags one more half cycle than the floating case
		for (int k = 0; k < 2; k++) begin
			set_pin(LIUDP_PIN_EDGE, k ? TRI_FLOAT : TRI_LOW);
			for (int n = 0; n < 40; n++) begin
				s = liudp_sym_t'(2'($random(seed)));
				s.neg = s.neg & ~s.pos;
				rx_step(s);
				if (n > 4) begin
					check_val("rx_pos", k ? d[1].pos : d[2].pos, sp);
					check_val("rx_neg", k ? d[1].neg : d[2].neg, sn);
				end
			end
		end
		set_pin(LIUDP_PIN_EDGE, TRI_LOW);
		zdis_n = 1'b0;
		for (int n = 0; n < 24; n++) begin
			ami_step(1'b1);
			if (n > 10) begin
				check_val("rx_nrz", 1, sp);
				check_val("rx_cv", 0, sn);
			end
		end
		rx_step(pol ? 2'b10 : 2'b01);
		hits = 0;
		repeat (10) begin
			ami_step(1'b0);
			hits += sn;
		end
		check_val("cv_pulses", 1, hits);
		set_pin(LIUDP_PIN_RATE, TRI_HIGH);
		repeat (60) ami_step(1'b1);
		check_val("status", 1, st);
		prbs_run(120, -1);
		check_val("status", 0, st);
		hits = 0;
		prbs_run(30, 2);
		check_val("err_pulse", 1, hits > 0 && hits < 4);
		check_val("status", 0, st);
		set_pin(LIUDP_PIN_RATE, TRI_LOW);
		prbs_run(120, -1);
		check_val("status", 1, st);
		los_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		repeat (5) begin
			@(posedge ref_clk);
			#3.5;
			check_val("rx_clk", mst_clk, rx_clk);
		end
		los_n = 1'b1;
		repeat (10) @(posedge ref_clk);
		#3.5;
		check_val("rx_clk", rec_clk, rx_clk);
		repeat (30) begin
			@(negedge tx_clk);
			check_val("tx_data", sent2, txd);
		end
		report_and_stop();
	end
endmodule
